// ==== logic/serial_irq_pkg.sv ====
// Purpose: shared constants and types for the serial, interrupt and keyboard register bank
// Assumes: 16-bit CPU address, 8-bit data, one 40 MHz clock
// Notes:   offsets are full CPU addresses
package serial_irq_pkg;
	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [15:0] ADDR_STATUS_RESET = 16'hD20A;
	localparam logic [15:0] ADDR_SERIAL_DATA  = 16'hD20D;
	localparam logic [15:0] ADDR_IRQ          = 16'hD20E;
	localparam logic [15:0] ADDR_SERIAL_KEY   = 16'hD20F;
	localparam logic [7:0]  RESET_IRQ_ENABLE  = 8'h00;
	localparam logic [7:0]  RESET_CONTROL     = 8'h00;
	localparam logic [7:0]  UNMAPPED_READ     = 8'hFF;

	// ----------------------------------------
	// interrupt bit map, shared by enable and status
	// ----------------------------------------
	localparam int IRQ_BREAK     = 7;
	localparam int IRQ_KEYPRESS  = 6;
	localparam int IRQ_RX_READY  = 5;
	localparam int IRQ_TX_NEEDED = 4;
	localparam int IRQ_TX_DONE   = 3;
	localparam int IRQ_TIMER4    = 2;
	localparam int IRQ_TIMER2    = 1;
	localparam int IRQ_TIMER1    = 0;

	// ----------------------------------------
	// control bits
	// ----------------------------------------
	localparam int CTL_FORCE_BREAK = 7;
	localparam int CTL_ASYNC_RX    = 4;
	localparam int CTL_TWO_TONE    = 3;
	localparam int CTL_FAST_POT    = 2;
	localparam int CTL_KEY_SCAN    = 1;
	localparam int CTL_KEY_DEBOUNCE = 0;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int          CLOCK_MHZ        = 40;
	localparam int          POT_SLOW_CYCLES  = 114;
	localparam logic [6:0]  POT_SLOW_LAST    = 7'(POT_SLOW_CYCLES - 1);
	localparam logic [3:0]  FRAME_DATA_LAST  = 4'h7;
	localparam logic [3:0]  TX_FRAME_BITS    = 4'hA;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic        write;
		logic        read;
	} reg_req_type;

	typedef enum logic [1:0] {
		RX_IDLE = 2'b00,
		RX_DATA = 2'b01,
		RX_STOP = 2'b11
	} rx_state_type;
endpackage

// ==== logic/serial_irq_keyboard_regs.sv ====
// Purpose: serial port, interrupt and keyboard register bank with its serial shifters
// Assumes: bit ticks and event pulses arrive one clock wide, synchronous to i_clock
// Notes:   one clock, no clock enable
//
// What this block does
// - transmit data write feeds output shifter
// - receive data read returns byte, clears ready
// - newer received byte overwrites unread one
// - overrun only while receive interrupt pending
// - enable and status share one bit map
// - enable 1 enables; 0 clears status, pending
// - enable writes never reset transmit-complete bit
// - idle output plus enable raises transmit-complete
// - latched status reads 0 pending, 1 otherwise
// - transmit-complete status is live, not latched
// - pending interrupts hold request until disabled
// - force break drives serial output low
// - async receive uses timer 4, resets timers
// - two-tone sends channel 1 or 2 tone
// - pot counters tick every 114 or 1
// - bits 1,0 scan/debounce; 00 initializes
// - input overrun when byte while receive pending
// - status bit 4 shows live input line
// - status reset write clears three error flags
`timescale 1ns/1ps
module serial_irq_keyboard_regs
	import serial_irq_pkg::*;
(
	// clock and reset
	input  wire logic                        i_clock,
	input  wire logic                        i_rstn,
	// register port
	input  wire serial_irq_pkg::reg_req_type i_bus,
	output logic [7:0]                       o_rdata,
	// interrupt sources and request
	input  wire logic                        i_break_key,
	input  wire logic                        i_keypress,
	input  wire logic                        i_timer1,
	input  wire logic                        i_timer2,
	input  wire logic                        i_timer4,
	output logic                             o_irq_n,
	// serial link
	input  wire logic                        i_rx_line,
	input  wire logic                        i_rx_clock_tick,
	input  wire logic                        i_tx_bit_tick,
	input  wire logic                        i_audio1,
	input  wire logic                        i_audio2,
	output logic                             o_serial_out,
	output logic                             o_timer34_reset,
	output logic                             o_rx_data_ready,
	// keyboard and pots
	input  wire logic                        i_shift_down,
	input  wire logic                        i_key_down,
	output logic                             o_key_scan_en,
	output logic                             o_key_debounce_en,
	output logic                             o_key_init,
	output logic                             o_pot_tick
);
	import serial_irq_pkg::*;

	// ----------------------------------------
	// register decode
	// ----------------------------------------
	logic       wr_enable, wr_control, wr_tx, wr_status_reset, rd_rx;
	logic [7:0] irq_enable_reg, serial_key_control_reg;

	assign wr_enable       = i_bus.write && (i_bus.addr == ADDR_IRQ);
	assign wr_control      = i_bus.write && (i_bus.addr == ADDR_SERIAL_KEY);
	assign wr_tx           = i_bus.write && (i_bus.addr == ADDR_SERIAL_DATA);
	assign wr_status_reset = i_bus.write && (i_bus.addr == ADDR_STATUS_RESET);
	assign rd_rx           = i_bus.read && (i_bus.addr == ADDR_SERIAL_DATA);

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			irq_enable_reg <= RESET_IRQ_ENABLE;
		end else if (wr_enable) begin
			irq_enable_reg <= i_bus.wdata;
		end
	end

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			serial_key_control_reg <= RESET_CONTROL;
		end else if (wr_control) begin
			serial_key_control_reg <= i_bus.wdata;
		end
	end

	// ----------------------------------------
	// transmit: holding register and shifter
	// ----------------------------------------
	logic [7:0] transmit_data_reg;
	logic       tx_hold_full_reg;
	logic [9:0] tx_shift_reg;
	logic [3:0] tx_count_reg;
	logic       tx_load, tx_busy;

	// a new byte waits in the holder until the shifter frees up
	assign tx_load = tx_hold_full_reg && (tx_count_reg == 4'h0);
	assign tx_busy = tx_hold_full_reg || (tx_count_reg != 4'h0);

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			transmit_data_reg <= 8'h00;
			tx_hold_full_reg  <= 1'b0;
		end else if (wr_tx) begin
			transmit_data_reg <= i_bus.wdata;
			tx_hold_full_reg  <= 1'b1;
		end else if (tx_load) begin
			tx_hold_full_reg  <= 1'b0;
		end
	end

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			tx_shift_reg <= 10'h3FF;
			tx_count_reg <= 4'h0;
		end else if (tx_load) begin
			tx_shift_reg <= {1'b1, transmit_data_reg, 1'b0};
			tx_count_reg <= TX_FRAME_BITS;
		end else if (i_tx_bit_tick && tx_count_reg != 4'h0) begin
			tx_shift_reg <= {1'b1, tx_shift_reg[9:1]};
			tx_count_reg <= tx_count_reg - 4'h1;
		end
	end

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			o_serial_out <= 1'b1;
		end else if (serial_key_control_reg[CTL_FORCE_BREAK]) begin
			o_serial_out <= 1'b0;
		end else if (serial_key_control_reg[CTL_TWO_TONE]) begin
			o_serial_out <= tx_shift_reg[0] ? i_audio1 : i_audio2;
		end else begin
			o_serial_out <= tx_shift_reg[0];
		end
	end

	// ----------------------------------------
	// receive shifter
	// ----------------------------------------
	rx_state_type rx_state_reg;
	logic [7:0]   receive_data_reg, rx_shift_reg;
	logic [3:0]   rx_count_reg;
	logic         rx_line_level, rx_tick, rx_done, rx_frame_bad;

	assign rx_line_level = i_rx_line; // inputs are synchronous
	assign rx_tick       = serial_key_control_reg[CTL_ASYNC_RX] ? i_timer4 : i_rx_clock_tick;
	assign rx_done       = rx_tick && (rx_state_reg == RX_STOP);
	assign rx_frame_bad  = rx_done && !rx_line_level;

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			rx_state_reg <= RX_IDLE;
			rx_shift_reg <= 8'h00;
			rx_count_reg <= 4'h0;
		end else if (rx_tick) begin
			case (rx_state_reg)
				RX_IDLE: begin
					if (!rx_line_level) begin
						rx_state_reg <= RX_DATA;
						rx_count_reg <= 4'h0;
					end
				end
				RX_DATA: begin
					rx_shift_reg <= {rx_line_level, rx_shift_reg[7:1]};
					rx_count_reg <= rx_count_reg + 4'h1;
					if (rx_count_reg == FRAME_DATA_LAST) begin
						rx_state_reg <= RX_STOP;
					end
				end
				RX_STOP: rx_state_reg <= RX_IDLE;
				default: rx_state_reg <= RX_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			receive_data_reg <= 8'h00;
		end else if (rx_done) begin
			receive_data_reg <= rx_shift_reg;
		end
	end

	// a completion in the same cycle as the read wins
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			o_rx_data_ready <= 1'b0;
		end else if (rx_done) begin
			o_rx_data_ready <= 1'b1;
		end else if (rd_rx) begin
			o_rx_data_ready <= 1'b0;
		end
	end

	// timers restart so the bit clock lines up with the next edge
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			o_timer34_reset <= 1'b0;
		end else begin
			o_timer34_reset <= serial_key_control_reg[CTL_ASYNC_RX]
				&& (rx_state_reg == RX_IDLE || !rx_line_level);
		end
	end

	// ----------------------------------------
	// interrupt status
	// ----------------------------------------
	logic [7:0] irq_pending_reg, irq_pending_next, irq_events, irq_enable_now;
	logic       tx_needed_pulse;

	assign tx_needed_pulse = tx_load;
	assign irq_enable_now  = wr_enable ? i_bus.wdata : irq_enable_reg; // a disabling write clears all but transmit done at once
	always_comb begin
		irq_events                = 8'h00;
		irq_events[IRQ_BREAK]     = i_break_key;
		irq_events[IRQ_KEYPRESS]  = i_keypress;
		irq_events[IRQ_RX_READY]  = rx_done;
		irq_events[IRQ_TX_NEEDED] = tx_needed_pulse;
		irq_events[IRQ_TIMER4]    = i_timer4;
		irq_events[IRQ_TIMER2]    = i_timer2;
		irq_events[IRQ_TIMER1]    = i_timer1;
		// disabled sources hold their status in the inactive state
		irq_pending_next          = (irq_pending_reg | irq_events) & irq_enable_now;
		// transmit done is live: the idle shifter with the enable set
		irq_pending_next[IRQ_TX_DONE] = irq_enable_reg[IRQ_TX_DONE] && !tx_busy;
	end

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			irq_pending_reg <= 8'h00;
		end else begin
			irq_pending_reg <= irq_pending_next;
		end
	end

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			o_irq_n <= 1'b1;
		end else begin
			o_irq_n <= ~|irq_pending_next;
		end
	end

	// ----------------------------------------
	// error flags, set wins over the reset strobe
	// ----------------------------------------
	logic frame_error_flag, key_overrun_flag, rx_overrun_flag;

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			frame_error_flag <= 1'b0;
			key_overrun_flag <= 1'b0;
			rx_overrun_flag  <= 1'b0;
		end else begin
			frame_error_flag <= rx_frame_bad
				|| (frame_error_flag && !wr_status_reset);
			key_overrun_flag <= (i_keypress && irq_pending_reg[IRQ_KEYPRESS])
				|| (key_overrun_flag && !wr_status_reset);
			rx_overrun_flag  <= (rx_done && irq_pending_reg[IRQ_RX_READY])
				|| (rx_overrun_flag && !wr_status_reset);
		end
	end

	// ----------------------------------------
	// pot counter rate and keyboard controls
	// ----------------------------------------
	logic [6:0] pot_div_reg;

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			pot_div_reg <= 7'h00;
			o_pot_tick  <= 1'b0;
		end else if (serial_key_control_reg[CTL_FAST_POT]) begin
			pot_div_reg <= 7'h00;
			o_pot_tick  <= 1'b1;
		end else begin
			pot_div_reg <= (pot_div_reg == POT_SLOW_LAST) ? 7'h00 : pot_div_reg + 7'h01;
			o_pot_tick  <= (pot_div_reg == POT_SLOW_LAST);
		end
	end

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			o_key_scan_en     <= 1'b0;
			o_key_debounce_en <= 1'b0;
			o_key_init        <= 1'b1;
		end else begin
			o_key_scan_en     <= serial_key_control_reg[CTL_KEY_SCAN];
			o_key_debounce_en <= serial_key_control_reg[CTL_KEY_DEBOUNCE];
			o_key_init        <= serial_key_control_reg[1:0] == 2'b00;
		end
	end

	// ----------------------------------------
	// read data, one cycle after the strobe
	// ----------------------------------------
	logic [7:0] status_view, serial_key_status_view;

	assign status_view = ~irq_pending_reg;
	assign serial_key_status_view = {~frame_error_flag, ~key_overrun_flag, ~rx_overrun_flag,
		rx_line_level, ~i_shift_down, ~i_key_down,
		rx_state_reg == RX_IDLE, 1'b1};

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			o_rdata <= 8'h00;
		end else if (i_bus.read) begin
			case (i_bus.addr)
				ADDR_SERIAL_DATA: o_rdata <= receive_data_reg;
				ADDR_IRQ:         o_rdata <= {status_view[7:4], tx_busy, status_view[2:0]};
				ADDR_SERIAL_KEY:  o_rdata <= serial_key_status_view;
				default:          o_rdata <= UNMAPPED_READ;
			endcase
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	chk_disable_clears: assert property (@(posedge i_clock) disable iff (!i_rstn)
		wr_enable && !i_bus.wdata[IRQ_TIMER1] |=> !irq_pending_reg[IRQ_TIMER1])
		else $error("disabled source still pending");
	chk_event_latches: assert property (@(posedge i_clock) disable iff (!i_rstn)
		i_timer2 && irq_enable_reg[IRQ_TIMER2] && !wr_enable
		|=> irq_pending_reg[IRQ_TIMER2] ##1 (irq_pending_reg[IRQ_TIMER2] || $past(wr_enable)))
		else $error("timer two status not latched");
	chk_irq_request: assert property (@(posedge i_clock) disable iff (!i_rstn)
		|irq_pending_reg |-> !o_irq_n)
		else $error("request dropped while pending");
	chk_tx_done_live: assert property (@(posedge i_clock) disable iff (!i_rstn)
		irq_enable_reg[IRQ_TX_DONE] && !tx_busy |=> irq_pending_reg[IRQ_TX_DONE])
		else $error("idle output did not raise transmit done");
	chk_force_break: assert property (@(posedge i_clock) disable iff (!i_rstn)
		serial_key_control_reg[CTL_FORCE_BREAK] |=> !o_serial_out)
		else $error("break not forced");
	chk_rx_overrun: assert property (@(posedge i_clock) disable iff (!i_rstn)
		rx_done && irq_pending_reg[IRQ_RX_READY] |=> rx_overrun_flag)
		else $error("overrun missed");
	chk_overrun_cause: assert property (@(posedge i_clock) disable iff (!i_rstn)
		$rose(rx_overrun_flag) |-> $past(rx_done) && $past(irq_pending_reg[IRQ_RX_READY]))
		else $error("overrun without pending receive");
	chk_status_reset: assert property (@(posedge i_clock) disable iff (!i_rstn)
		wr_status_reset && !rx_done && !i_keypress |=> !frame_error_flag && !key_overrun_flag)
		else $error("status reset failed");
	chk_pot_slow: assert property (@(posedge i_clock) disable iff (!i_rstn)
		o_pot_tick && !serial_key_control_reg[CTL_FAST_POT] && !wr_control
		|=> !o_pot_tick)
		else $error("slow pot tick too often");
	chk_rx_read: assert property (@(posedge i_clock) disable iff (!i_rstn)
		rd_rx && !rx_done |=> !o_rx_data_ready && o_rdata == $past(receive_data_reg))
		else $error("receive read wrong");
	cov_byte_in: cover property (@(posedge i_clock) disable iff (!i_rstn) rx_done);
	cov_byte_out: cover property (@(posedge i_clock) disable iff (!i_rstn)
		tx_load ##[1:400] !tx_busy);
	cov_overrun: cover property (@(posedge i_clock) disable iff (!i_rstn) $rose(rx_overrun_flag));
endmodule

// ==== verification/serial_peer.sv ====
// Purpose: behavioural peripheral on the serial peripheral bus, sending framed bytes
// Assumes: one bit tick per bit, line set up three clocks before its tick
// Notes:   tick stands still between frames; the line idles high like a pulled-up mark
`timescale 1ns/1ps
module serial_peer (
	// clock
	input  wire logic       i_clock,
	// frame request
	input  wire logic       i_send,
	input  wire logic [7:0] i_byte,
	input  wire logic       i_stop_bit,
	input  wire logic       i_hold_low,
	// serial side
	output logic            o_line,
	output logic            o_tick,
	output logic            o_busy
);
	logic [9:0] frame;
	logic       line;
	int         k;

	assign o_line = i_hold_low ? 1'b0 : line;

	initial begin
		line = 1'b1;
		o_tick = 1'b0;
		o_busy = 1'b0;
		forever begin
			@(posedge i_clock);
			if (i_send) begin
				o_busy <= 1'b1;
				// start 0, data lsb first, then the stop level asked for
				frame = {i_stop_bit, i_byte, 1'b0};
				for (k = 0; k < 10; k++) begin
					line <= frame[k];
					repeat (3) @(posedge i_clock);
					o_tick <= 1'b1;
					@(posedge i_clock);
					o_tick <= 1'b0;
				end
				line <= 1'b1;
				repeat (2) @(posedge i_clock);
				o_busy <= 1'b0;
			end
		end
	end
endmodule

// ==== verification/serial_irq_keyboard_regs_bench.sv ====
// Purpose: self-checking bench for the serial, interrupt and keyboard register bank
// Assumes: the peer model drives the receive line and its bit tick
// Notes:   random values come from an 8-bit lfsr seeded with 22
`timescale 1ns/1ps
module serial_irq_keyboard_regs_bench;
	import serial_irq_pkg::*;
	logic        i_clock;
	logic        i_rstn;
	reg_req_type bus;
	logic [7:0]  ev;
	logic [7:0]  seed;
	logic [7:0]  en;
	logic [7:0]  p;
	logic [7:0]  send_byte;
	logic        tx_tick, audio1, audio2, shift_down, key_down;
	logic        send, stop_bit, hold_low, rx_line, rx_tick, peer_busy;
	logic [7:0]  o_rdata;
	logic        o_irq_n, o_serial_out, o_timer34_reset, o_rx_data_ready;
	logic        o_key_scan_en, o_key_debounce_en, o_key_init, o_pot_tick;
	int          errors = 0;
	int          n_tests = 0;
	int          cycles = 0;
	int          k;

	serial_irq_keyboard_regs serial_irq_keyboard_regs_i (
		.i_clock(i_clock), .i_rstn(i_rstn), .i_bus(bus), .o_rdata(o_rdata),
		.i_break_key(ev[IRQ_BREAK]), .i_keypress(ev[IRQ_KEYPRESS]), .i_timer1(ev[IRQ_TIMER1]),
		.i_timer2(ev[IRQ_TIMER2]), .i_timer4(ev[IRQ_TIMER4]), .o_irq_n(o_irq_n),
		.i_rx_line(rx_line), .i_rx_clock_tick(rx_tick), .i_tx_bit_tick(tx_tick),
		.i_audio1(audio1), .i_audio2(audio2), .o_serial_out(o_serial_out),
		.o_timer34_reset(o_timer34_reset), .o_rx_data_ready(o_rx_data_ready),
		.i_shift_down(shift_down), .i_key_down(key_down), .o_key_scan_en(o_key_scan_en),
		.o_key_debounce_en(o_key_debounce_en), .o_key_init(o_key_init), .o_pot_tick(o_pot_tick));

	serial_peer serial_peer_i (
		.i_clock(i_clock), .i_send(send), .i_byte(send_byte), .i_stop_bit(stop_bit),
		.i_hold_low(hold_low), .o_line(rx_line), .o_tick(rx_tick), .o_busy(peer_busy));

	initial begin
		i_clock = 1'b0;
		forever #12.5 i_clock = ~i_clock;
	end

	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	task automatic finish_test();
		$display("tests %0d, mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// the whole run is under a thousand clocks; this only catches a hang
	always @(posedge i_clock) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			errors = errors + 1;
			finish_test();
		end
	end

	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("unexpected %s: expected %h, seen %h", name, exp, got);
		end
	endtask

	task automatic wait_n(input int n);
		repeat (n) @(posedge i_clock);
		#1;
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge i_clock);
		bus <= '{addr: a, wdata: d, write: 1'b1, read: 1'b0};
		@(posedge i_clock);
		bus.write <= 1'b0;
	endtask

	// read data appear in the cycle after the strobe and hold until the next read
	task automatic rd(input logic [15:0] a, input logic [7:0] exp, input string name);
		@(posedge i_clock);
		bus <= '{addr: a, wdata: 8'h00, write: 1'b0, read: 1'b1};
		@(posedge i_clock);
		bus.read <= 1'b0;
		#1;
		chk(name, exp, o_rdata);
	endtask

	task automatic pulse(input logic [7:0] m);
		@(posedge i_clock);
		ev <= m;
		@(posedge i_clock);
		ev <= 8'h00;
	endtask

	task automatic txbit();
		@(posedge i_clock);
		tx_tick <= 1'b1;
		@(posedge i_clock);
		tx_tick <= 1'b0;
		wait_n(2);
	endtask

	task automatic frame(input logic [7:0] b, input logic s);
		@(posedge i_clock);
		send <= 1'b1;
		send_byte <= b;
		stop_bit <= s;
		@(posedge i_clock);
		send <= 1'b0;
		#1;
		for (k = 0; k < 400 && peer_busy; k++) @(posedge i_clock);
		wait_n(2);
	endtask

	initial begin
		i_rstn = 1'b0;
		bus = '0;
		ev = 8'h00;
		{tx_tick, audio1, audio2, shift_down, key_down, send, stop_bit, hold_low} = 8'h00;
		send_byte = 8'h00;
		repeat (10) @(posedge i_clock);
		i_rstn <= 1'b0 | 1'b1;
		// ----------------------------------------
		// reset values and decode
		// ----------------------------------------
		rd(ADDR_IRQ, 8'hF7, "status at reset");
		rd(ADDR_SERIAL_KEY, 8'hFF, "serial status at reset");
		rd(16'hD200, UNMAPPED_READ, "unmapped");
		$display("test reset done");
		// ----------------------------------------
		// event interrupt sources: random masks, then all five at once
		// ----------------------------------------
		seed = 8'h16;
		for (int i = 0; i < 9; i++) begin
			seed = lfsr(seed);
			en = (i == 8) ? 8'hC7 : seed & 8'hC7;
			seed = lfsr(seed);
			p = (i == 8) ? 8'hC7 : seed & 8'hC7;
			wr(ADDR_IRQ, en);
			pulse(p);
			wait_n(2);
			chk("irq_n", 8'((en & p) == 8'h00), 8'(o_irq_n));
			rd(ADDR_IRQ, ~(en & p) & 8'hF7, "status pending");
			wr(ADDR_IRQ, 8'h00);
			rd(ADDR_IRQ, 8'hF7, "status cleared");
			chk("irq_n cleared", 8'h01, 8'(o_irq_n));
		end
		$display("test interrupts done");
		// ----------------------------------------
		// transmit frame and transmit-complete
		// ----------------------------------------
		wr(ADDR_IRQ, 8'h08);
		wait_n(3);
		chk("tx done irq_n", 8'h00, 8'(o_irq_n));
		wr(ADDR_IRQ, 8'h18);
		seed = lfsr(seed);
		wr(ADDR_SERIAL_DATA, seed);
		wait_n(3);
		chk("start bit", 8'h00, 8'(o_serial_out));
		rd(ADDR_IRQ, 8'hEF, "tx busy status");
		wr(ADDR_IRQ, 8'h08);
		rd(ADDR_IRQ, 8'hFF, "enable write while busy");
		for (k = 0; k < 9; k++) begin
			txbit();
			chk("tx bit", 8'((k < 8) ? seed[k] : 1'b1), 8'(o_serial_out));
		end
		txbit();
		txbit();
		chk("tx done again", 8'h00, 8'(o_irq_n));
		rd(ADDR_IRQ, 8'hF7, "tx idle status");
		wr(ADDR_IRQ, 8'h00);
		wait_n(2);
		chk("tx irq off", 8'h01, 8'(o_irq_n));
		$display("test transmit done");
		// ----------------------------------------
		// receive, overwrite, overrun, frame error
		// ----------------------------------------
		wr(ADDR_IRQ, 8'h20);
		seed = lfsr(seed);
		frame(seed, 1'b1);
		chk("rx ready", 8'h01, 8'(o_rx_data_ready));
		rd(ADDR_SERIAL_DATA, seed, "rx byte");
		chk("rx ready cleared", 8'h00, 8'(o_rx_data_ready));
		frame(8'h3C, 1'b1);
		frame(8'hC3, 1'b1);
		rd(ADDR_SERIAL_KEY, 8'hDF, "rx overrun");
		rd(ADDR_SERIAL_DATA, 8'hC3, "rx overwrite");
		wr(ADDR_STATUS_RESET, 8'h00);
		rd(ADDR_SERIAL_KEY, 8'hFF, "status reset");
		wr(ADDR_IRQ, 8'h00);
		frame(8'h11, 1'b1);
		frame(8'h22, 1'b1);
		rd(ADDR_SERIAL_KEY, 8'hFF, "no overrun unread");
		rd(ADDR_SERIAL_DATA, 8'h22, "rx second byte");
		frame(8'h5A, 1'b0);
		rd(ADDR_SERIAL_KEY, 8'h7F, "frame error");
		wr(ADDR_STATUS_RESET, 8'hA5);
		rd(ADDR_SERIAL_KEY, 8'hFF, "frame error reset");
		hold_low <= 1'b1;
		rd(ADDR_SERIAL_KEY, 8'hEF, "line low");
		hold_low <= 1'b0;
		$display("test receive done");
		// ----------------------------------------
		// keyboard status
		// ----------------------------------------
		wr(ADDR_IRQ, 8'h40);
		pulse(8'h40);
		pulse(8'h40);
		rd(ADDR_SERIAL_KEY, 8'hBF, "key overrun");
		wr(ADDR_STATUS_RESET, 8'h00);
		wr(ADDR_IRQ, 8'h00);
		shift_down <= 1'b1;
		key_down <= 1'b1;
		rd(ADDR_SERIAL_KEY, 8'hF3, "keys held");
		shift_down <= 1'b0;
		key_down <= 1'b0;
		$display("test keyboard done");
		// ----------------------------------------
		// control bits
		// ----------------------------------------
		for (int i = 0; i < 4; i++) begin
			wr(ADDR_SERIAL_KEY, 8'(i));
			wait_n(2);
			chk("scan bits", 8'({i[1], i[0], i == 0}),
				8'({o_key_scan_en, o_key_debounce_en, o_key_init}));
		end
		wr(ADDR_SERIAL_KEY, 8'h04);
		wait_n(3);
		for (int i = 0; i < 4; i++) begin
			chk("fast pot", 8'h01, 8'(o_pot_tick));
			wait_n(1);
		end
		wr(ADDR_SERIAL_KEY, 8'h00);
		wait_n(1);
		for (k = 0; k < 300 && !o_pot_tick; k++) wait_n(1);
		wait_n(1);
		for (k = 1; k < 300 && !o_pot_tick; k++) wait_n(1);
		chk("slow pot period", 8'(POT_SLOW_CYCLES), 8'(k));
		wr(ADDR_SERIAL_KEY, 8'h10);
		wait_n(3);
		chk("timer reset async", 8'h01, 8'(o_timer34_reset));
		wr(ADDR_SERIAL_KEY, 8'h80);
		wait_n(3);
		chk("timer reset off", 8'h00, 8'(o_timer34_reset));
		chk("force break", 8'h00, 8'(o_serial_out));
		wr(ADDR_SERIAL_KEY, 8'h08);
		audio2 <= 1'b1;
		wait_n(3);
		chk("two tone mark", 8'h00, 8'(o_serial_out));
		audio1 <= 1'b1;
		wait_n(3);
		chk("two tone mark high", 8'h01, 8'(o_serial_out));
		// a start bit is a zero, so channel 2 must show on the line
		audio1 <= 1'b0;
		wr(ADDR_SERIAL_DATA, 8'hFF);
		wait_n(3);
		chk("two tone space", 8'h01, 8'(o_serial_out));
		for (k = 0; k < 10; k++) txbit();
		wr(ADDR_SERIAL_KEY, 8'h00);
		audio1 <= 1'b0;
		wait_n(3);
		chk("normal output", 8'h01, 8'(o_serial_out));
		$display("test control done");
		finish_test();
	end
endmodule
